/* File: core/wdt_pkg.sv */
// Shared constants for the watchdog device end and the I/O host end.
// Assumes both ends run on one 50 MHz clock with a synchronous reset.
package wdt_pkg;
  //////////////////////////////////////////////////////////////////////////
  // Fixed I/O ports and key bytes.
  localparam logic [15:0] INDEX_PORT = 16'h0302;
  localparam logic [15:0] DATA_PORT  = 16'h0303;
  localparam logic [15:0] POST_PORT  = 16'h0080;
  localparam logic [7:0]  KEY_A      = 8'h46;
  localparam logic [7:0]  KEY_B      = 8'h57;
  // Configuration indices.
  localparam logic [7:0] IDX_LDS      = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_COUNT0   = 8'h38;
  localparam logic [7:0] IDX_COUNT1   = 8'h39;
  localparam logic [7:0] IDX_COUNT2   = 8'h3a;
  localparam logic [7:0] IDX_RELOAD0  = 8'h3b;
  localparam logic [7:0] IDX_RELOAD1  = 8'h3c;
  localparam logic [7:0] IDX_RELOAD2  = 8'h3d;
  localparam logic [7:0] IDX_STATUS   = 8'h3e;
  localparam logic [7:0] IDX_CONTROL  = 8'h3f;
  localparam logic [7:0] IDX_BASE_HI  = 8'h60;
  localparam logic [7:0] IDX_BASE_LO  = 8'h61;
  localparam logic [7:0] IDX_ROUTE    = 8'h70;
  localparam logic [7:0] IDX_STROBE   = 8'hf1;
  localparam logic [7:0] IDX_W1_LO    = 8'hf2;
  localparam logic [7:0] IDX_W1_HI    = 8'hf3;
  localparam logic [7:0] IDX_W2_LO    = 8'hf4;
  localparam logic [7:0] IDX_W2_HI    = 8'hf5;
  localparam logic [7:0] IDX_MASKS    = 8'hf6;
  // Reset values.
  localparam logic [7:0]  WATCHDOG_DEVICE = 8'h01;
  localparam logic [7:0]  LDS_RESET       = 8'h01;
  localparam logic [23:0] RELOAD_RESET    = 24'h004000;
  localparam logic [23:0] COUNT_MAX       = 24'hffffff;
  localparam logic [7:0]  CONTROL_RESET   = 8'h03;
  localparam logic [7:0]  MASKS_RESET     = 8'hff;
  localparam logic [7:0]  UNCLAIMED       = 8'hff;
  // Field positions.
  localparam int SM_W1_RD = 0;
  localparam int SM_W1_WR = 1;
  localparam int SM_W2_RD = 2;
  localparam int SM_W2_WR = 3;
  localparam int SM_POST  = 4;
  localparam int ST_EXPIRED = 0;
  localparam logic [3:0] ROUTE_OFF = 4'h0;
  localparam logic [3:0] ROUTE_SMI = 4'h2;
  // Time base derived from the reference clock.
  localparam int REF_CLK_HZ   = 50_000_000;
  localparam int TIME_BASE_HZ = 32_768;
  localparam int TICK_DIV     = REF_CLK_HZ / TIME_BASE_HZ;
  // Host register byte offsets and command bits.
  localparam logic [3:0] HOST_ADDR   = 4'h0;
  localparam logic [3:0] HOST_WDATA  = 4'h4;
  localparam logic [3:0] HOST_CMD    = 4'h8;
  localparam logic [3:0] HOST_STATUS = 4'hc;
  localparam int CMD_GO    = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_ENTER = 2;
  localparam int CMD_EXIT  = 3;
  // Host sequencer states.
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_REQ  = 3'b010,
    H_GAP  = 3'b100
  } host_state_t;
endpackage

/* File: core/wdt_link_if.sv */
// Byte-wide I/O cycle link between the host end and the watchdog end.
// Assumes both ends share one clock; no clocking inside.
`timescale 1ns/1ps
interface wdt_link_if;
  logic        io_req;
  logic        io_wr;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_ack;
  modport host_end (output io_req, output io_wr, output io_addr,
                    output io_wdata, input io_rdata, input io_ack);
  modport device_end (input io_req, input io_wr, input io_addr,
                      input io_wdata, output io_rdata, output io_ack);
endinterface // wdt_link_if

/* File: core/wdt_device.sv */
// Watchdog logical device answering I/O cycles on the link.
// Assumes the host holds each request until acknowledged.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module wdt_device
  import wdt_pkg::*;
#(
  parameter int TICK_CYCLES = wdt_pkg::TICK_DIV
)(
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  wdt_link_if.device_end  link,
  output logic            WD_IRQ,
  output logic [3:0]      WD_IRQ_LINE,
  output logic            WD_SMI,
  output logic            WD_RESET
);
  import wdt_pkg::*;
  logic [10:0] tick_cnt;
  logic [23:0] count, reload;
  logic [15:0] io_base, win1_base, win2_base;
  logic [7:0]  index, lds, control, masks, rdata, acc_idx, read_val;
  logic [4:0]  strobe_mode;
  logic [3:0]  route;
  logic        tick, cfg_mode, key_half, activate, expired, ack, take;
  logic        wr, at_index, at_data, io_hit, acc, acc_wr, dev_sel;
  logic        win1_hit, win2_hit, strobe, expire;
  //////////////////////////////////////////////////////////////////////////
  // The 32.768 kHz time base is a divider of the reference clock; the
  // integer divide makes each tick slightly faster than the ideal rate.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 11'd1;
  end
  assign tick = (tick_cnt == 11'(TICK_CYCLES - 1));
  //////////////////////////////////////////////////////////////////////////
  // Cycle decode. A request is taken once; the ack flop blocks a retake.
  assign take     = link.io_req && !ack;
  assign wr       = take && link.io_wr;
  assign at_index = cfg_mode && (link.io_addr == INDEX_PORT);
  assign at_data  = cfg_mode && (link.io_addr == DATA_PORT);
  assign dev_sel  = (lds == WATCHDOG_DEVICE);
  assign io_hit   = activate && !at_index && !at_data
                    && (link.io_addr[15:3] == io_base[15:3]);
  assign acc      = take && (at_data || io_hit);
  assign acc_wr   = acc && link.io_wr;
  // I/O offsets map onto the same indices as the data port.
  assign acc_idx  = io_hit ? (IDX_COUNT0 | {5'h00, link.io_addr[2:0]})
                           : index;

  // The low address bits picked by a mask are ignored in the compare.
  assign win1_hit = ((link.io_addr ^ win1_base)
                    & ~{12'h000, masks[7:4]}) == 16'h0000;
  assign win2_hit = ((link.io_addr ^ win2_base)
                    & ~{12'h000, masks[3:0]}) == 16'h0000;

  // Every restart source; the written value of the count is discarded.
  assign strobe =
    (acc_wr && (dev_sel || io_hit) && acc_idx >= IDX_COUNT0
      && acc_idx <= IDX_COUNT2)
    || (wr && link.io_addr == POST_PORT
      && strobe_mode[SM_POST])
    || (take && win1_hit && (link.io_wr ? strobe_mode[SM_W1_WR]
                                        : strobe_mode[SM_W1_RD]))
    || (take && win2_hit && (link.io_wr ? strobe_mode[SM_W2_WR]
                                        : strobe_mode[SM_W2_RD]));

  //////////////////////////////////////////////////////////////////////////
  // Key tracking on the index port. In configuration every write there
  // is also an index write, so the exit key leaves the index at 46h.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      cfg_mode <= 1'b0;
      key_half <= 1'b0;
    end
    else if (wr && link.io_addr == INDEX_PORT)
    begin
      if (!cfg_mode)
      begin
        if (key_half && link.io_wdata == KEY_B)
          cfg_mode <= 1'b1;
        key_half <= (link.io_wdata == KEY_A);
      end
      else
      begin
        if (key_half && link.io_wdata == KEY_A)
          cfg_mode <= 1'b0;
        key_half <= (link.io_wdata == KEY_B);
      end
    end
  end

  // Index register behind the index port.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      index <= 8'h00;
    else if (wr && at_index)
      index <= link.io_wdata;
  end
  //////////////////////////////////////////////////////////////////////////
  // Configuration storage. The device-select index is global; the rest
  // answers only while this device is selected or through its I/O range.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      lds         <= LDS_RESET;
      activate    <= 1'b1;
      reload      <= RELOAD_RESET;
      control     <= CONTROL_RESET;
      io_base     <= 16'h0000;
      route       <= ROUTE_OFF;
      strobe_mode <= 5'h00;
      win1_base   <= 16'h0000;
      win2_base   <= 16'h0000;
      masks       <= MASKS_RESET;
    end
    else if (acc_wr && at_data && acc_idx == IDX_LDS)
      lds <= link.io_wdata;
    else if (acc_wr && (dev_sel || io_hit))
    begin
      unique case (acc_idx)
        IDX_ACTIVATE: activate       <= link.io_wdata[0];
        IDX_RELOAD0:  reload[7:0]    <= link.io_wdata;
        IDX_RELOAD1:  reload[15:8]   <= link.io_wdata;
        IDX_RELOAD2:  reload[23:16]  <= link.io_wdata;
        IDX_CONTROL:  control        <= link.io_wdata;
        IDX_BASE_HI:  io_base[15:8]  <= link.io_wdata;
        IDX_BASE_LO:  io_base[7:0]   <= link.io_wdata;
        IDX_ROUTE:    route          <= link.io_wdata[3:0];
        IDX_STROBE:   strobe_mode    <= link.io_wdata[4:0];
        IDX_W1_LO:    win1_base[7:0]  <= link.io_wdata;
        IDX_W1_HI:    win1_base[15:8] <= link.io_wdata;
        IDX_W2_LO:    win2_base[7:0]  <= link.io_wdata;
        IDX_W2_HI:    win2_base[15:8] <= link.io_wdata;
        IDX_MASKS:    masks          <= link.io_wdata;
        default:      activate       <= activate;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Countdown. Reset loads the maximum so an unprogrammed unit still
  // guards the boot; the count holds at zero once expired.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      count <= COUNT_MAX;
    else if (strobe)
      count <= reload;
    else if (activate && tick && count != 24'h000000)
      count <= count - 24'h000001;
  end
  assign expire = activate && tick && !strobe
                  && count == 24'h000001;
  // Sticky expiry flag; a set in the clearing cycle wins.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      expired <= 1'b0;
    else if (expire)
      expired <= 1'b1;
    else if (acc_wr && (dev_sel || io_hit) && acc_idx == IDX_STATUS
             && link.io_wdata[ST_EXPIRED])
      expired <= 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // Expiry action, held until the next restart. Route 0 falls back to a
  // system reset; routes printed as unsupported give no action at all.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || strobe)
    begin
      WD_IRQ      <= 1'b0;
      WD_IRQ_LINE <= 4'h0;
      WD_SMI      <= 1'b0;
      WD_RESET    <= 1'b0;
    end
    else if (expire)
    begin
      unique case (route)
        ROUTE_OFF: WD_RESET <= 1'b1;
        ROUTE_SMI: WD_SMI   <= 1'b1;
        4'h8, 4'hd, 4'he, 4'hf: WD_RESET <= 1'b0;
        default:
        begin
          WD_IRQ      <= 1'b1;
          WD_IRQ_LINE <= route;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Read value of the addressed register; reserved bits read as zero.
  always_comb
  begin
    read_val = 8'h00;
    if (at_index)
      read_val = index;
    else if (at_data && acc_idx == IDX_LDS)
      read_val = lds;
    else if (!(dev_sel || io_hit))
      read_val = UNCLAIMED;
    else
    begin
      unique case (acc_idx)
        IDX_ACTIVATE: read_val = {7'h00, activate};
        IDX_COUNT0:   read_val = count[7:0];
        IDX_COUNT1:   read_val = count[15:8];
        IDX_COUNT2:   read_val = count[23:16];
        IDX_RELOAD0:  read_val = reload[7:0];
        IDX_RELOAD1:  read_val = reload[15:8];
        IDX_RELOAD2:  read_val = reload[23:16];
        IDX_STATUS:   read_val = {7'h00, expired};
        IDX_CONTROL:  read_val = control;
        IDX_BASE_HI:  read_val = io_base[15:8];
        IDX_BASE_LO:  read_val = io_base[7:0];
        IDX_ROUTE:    read_val = {4'h0, route};
        IDX_STROBE:   read_val = {3'h0, strobe_mode};
        IDX_W1_LO:    read_val = win1_base[7:0];
        IDX_W1_HI:    read_val = win1_base[15:8];
        IDX_W2_LO:    read_val = win2_base[7:0];
        IDX_W2_HI:    read_val = win2_base[15:8];
        IDX_MASKS:    read_val = masks;
        default:      read_val = 8'h00;
      endcase
    end
  end
  // Every cycle, claimed or not, is acknowledged one clock after it is
  // taken, so the host can never hang on a stray address.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ack   <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      ack <= take;
      if (take && !link.io_wr)
        rdata <= (at_index || acc) ? read_val : UNCLAIMED;
    end
  end
  assign link.io_ack   = ack;
  assign link.io_rdata = rdata;
endmodule // wdt_device

/* File: core/wdt_host.sv */
// I/O host end: turns Avalon-MM register orders into link cycles.
// Assumes one device end on the link and the same clock on both ends.
`timescale 1ns/1ps
module wdt_host
  import wdt_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  wdt_link_if.host_end     link
);
  import wdt_pkg::*;

  host_state_t state;
  logic        take;
  logic        go;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  second;
  logic        two_ops;
  logic        req;
  logic        req_wr;
  logic [15:0] req_addr;
  logic [7:0]  req_data;

  //////////////////////////////////////////////////////////////////////////
  // Slave handshake: every request waits exactly one cycle.
  assign take = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  assign go   = take && AVS_WRITE && AVS_ADDRESS == HOST_CMD
                && state == H_IDLE;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !take;
  end

  // Read data; unmapped offsets and the command word read as zero.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      AVS_READDATA <= 32'h00000000;
    else if (take && AVS_READ)
    begin
      unique case (AVS_ADDRESS)
        HOST_ADDR:   AVS_READDATA <= {16'h0000, addr};
        HOST_WDATA:  AVS_READDATA <= {24'h000000, wdata};
        HOST_STATUS: AVS_READDATA <= {16'h0000, rdata, 7'h00,
                                      state != H_IDLE};
        default:     AVS_READDATA <= 32'h00000000;
      endcase
    end
  end

  // Software-held address and data for single cycles.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      addr  <= 16'h0000;
      wdata <= 8'h00;
    end
    else if (take && AVS_WRITE && AVS_ADDRESS == HOST_ADDR)
      addr <= AVS_WRITEDATA[15:0];
    else if (take && AVS_WRITE && AVS_ADDRESS == HOST_WDATA)
      wdata <= AVS_WRITEDATA[7:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // Cycle sequencer. Key orders issue two index-port writes with an idle
  // cycle between them; a command while busy is dropped.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state    <= H_IDLE;
      req      <= 1'b0;
      req_wr   <= 1'b0;
      req_addr <= 16'h0000;
      req_data <= 8'h00;
      second   <= 8'h00;
      two_ops  <= 1'b0;
      rdata    <= 8'h00;
    end
    else
    begin
      unique case (state)
        H_IDLE:
          if (go && AVS_WRITEDATA[CMD_ENTER])
          begin
            state <= H_REQ;
            {req, req_wr, req_addr} <= {2'b11, INDEX_PORT};
            req_data <= KEY_A;
            second   <= KEY_B;
            two_ops  <= 1'b1;
          end
          else if (go && AVS_WRITEDATA[CMD_EXIT])
          begin
            state <= H_REQ;
            {req, req_wr, req_addr} <= {2'b11, INDEX_PORT};
            req_data <= KEY_B;
            second   <= KEY_A;
            two_ops  <= 1'b1;
          end
          else if (go && AVS_WRITEDATA[CMD_GO])
          begin
            state    <= H_REQ;
            req      <= 1'b1;
            req_wr   <= AVS_WRITEDATA[CMD_WRITE];
            req_addr <= addr;
            req_data <= wdata;
            two_ops  <= 1'b0;
          end
        H_REQ:
          if (link.io_ack)
          begin
            req <= 1'b0;
            if (!req_wr)
              rdata <= link.io_rdata;
            state <= two_ops ? H_GAP : H_IDLE;
          end
        H_GAP:
        begin
          state    <= H_REQ;
          req      <= 1'b1;
          req_data <= second;
          two_ops  <= 1'b0;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
  assign link.io_req   = req;
  assign link.io_wr    = req_wr;
  assign link.io_addr  = req_addr;
  assign link.io_wdata = req_data;
endmodule // wdt_host

/* File: tb/wdt_chk.sv */
// Checker for the byte link between the host end and the watchdog end.
// Assumes one clock and a synchronous active-high reset on that clock.
`timescale 1ns/1ps
module wdt_chk
  import wdt_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        io_req,
  input wire logic        io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_ack
);
  logic       tk;
  logic       cfg;
  logic [7:0] last_key;
  logic [7:0] idx;
  logic [7:0] lds;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////
  // A request is taken on an edge where it is up and not yet answered.
  assign tk = io_req && !io_ack;
  // Mirror of key, index and selection, rebuilt from taken writes only.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      cfg      <= 1'b0;
      last_key <= 8'h00;
      idx      <= 8'h00;
      lds      <= LDS_RESET;
    end
    else if (tk && io_wr && io_addr == INDEX_PORT)
    begin
      last_key <= io_wdata;
      if (cfg)
        idx <= io_wdata;
      if (!cfg && last_key == KEY_A && io_wdata == KEY_B)
        cfg <= 1'b1;
      if (cfg && last_key == KEY_B && io_wdata == KEY_A)
        cfg <= 1'b0;
    end
    else if (tk && io_wr && cfg && io_addr == DATA_PORT && idx == IDX_LDS)
      lds <= io_wdata;
  end
  ////////////////////////////////////////////////////////////
  // Handshake timing and the answers of the index and data ports.
  a_ack_follows: assert property (tk |=> io_ack)
    else $error("link request not answered in one cycle");
  a_ack_pulse: assert property (io_ack |=> !io_ack)
    else $error("link answer longer than one cycle");
  a_ack_cause: assert property (io_ack |-> $past(tk))
    else $error("link answer without a request");
  a_req_holds: assert property (tk |=> io_req && $stable(io_addr)
    && $stable(io_wr) && $stable(io_wdata))
    else $error("link request changed before its answer");
  a_req_release: assert property (io_ack |=> !io_req)
    else $error("link request not released after answer");
  a_port_closed: assert property (tk && !io_wr && !cfg &&
    (io_addr == INDEX_PORT || io_addr == DATA_PORT) |=> io_rdata == UNCLAIMED)
    else $error("closed port answered outside configuration");
  a_index_read: assert property (tk && !io_wr && cfg &&
    io_addr == INDEX_PORT |=> io_rdata == idx)
    else $error("index port read wrong value");
  a_select_read: assert property (tk && !io_wr && cfg &&
    io_addr == DATA_PORT && idx == IDX_LDS |=> io_rdata == lds)
    else $error("device selection read wrong value");
  c_enter: cover property ($rose(cfg));
  c_closed: cover property (tk && !io_wr && !cfg && io_addr == DATA_PORT);
  c_select: cover property (tk && io_wr && cfg && idx == IDX_LDS);
endmodule // wdt_chk

/* File: tb/lpc_watchdog_timer_tb_top.sv */
// Bench joining the host end and the watchdog end over the link.
// Assumes a short tick parameter so that timeouts take few cycles.
`timescale 1ns/1ps
module lpc_watchdog_timer_tb_top;
  import wdt_pkg::*;
  localparam int TK = 2;
  logic        REF_CLK;
  logic        RST = 1'b1;
  logic [3:0]  AVS_ADDRESS = 4'h0;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        WD_IRQ;
  logic [3:0]  WD_IRQ_LINE;
  logic        WD_SMI;
  logic        WD_RESET;
  int          err_total = 0;
  int          checks_done = 0;
  int          n_ld;
  logic [31:0] seed = 32'h39;
  logic [31:0] rdq;
  logic [7:0]  q;
  // Reset table, then strobe table: address, direction, mode, survives.
  logic [7:0]  ri [13] = '{8'h07, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f,
    8'h70, 8'hf0, 8'hf1, 8'hf2, 8'hf5, 8'hf6, 8'h3a};
  logic [7:0]  rv [13] = '{8'h01, 8'h00, 8'h40, 8'h00, 8'h00, 8'h03,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
  logic [15:0] sa [8] = '{16'h0080, 16'h0080, 16'h0203, 16'h0204,
    16'h040f, 16'h040f, 16'h0500, 16'h0503};
  logic        sw [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [7:0]  sm [8] = '{8'h10, 8'h00, 8'h01, 8'h01, 8'h08, 8'h04,
    8'h00, 8'h00};
  logic        sk [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  wdt_link_if link ();
  wdt_host wdt_host_i (.REF_CLK(REF_CLK), .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .link(link));
  wdt_device #(.TICK_CYCLES(TK)) wdt_device_i (.REF_CLK(REF_CLK),
    .RST(RST), .link(link), .WD_IRQ(WD_IRQ), .WD_IRQ_LINE(WD_IRQ_LINE),
    .WD_SMI(WD_SMI), .WD_RESET(WD_RESET));
  wdt_chk wdt_chk_i (.REF_CLK(REF_CLK), .RST(RST), .io_req(link.io_req),
    .io_wr(link.io_wr), .io_addr(link.io_addr), .io_wdata(link.io_wdata),
    .io_rdata(link.io_rdata), .io_ack(link.io_ack));
  ////////////////////////////////////////////////////////////
  // Comparison, random source and bus tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge REF_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    n = 0;
    do
    begin
      @(posedge REF_CLK);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'b0 && n < 64);
    rdq = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (n >= 64)
      chk(32'(n), 32'h0);
  endtask
  // Issues a command and polls busy; the read byte lands in q.
  task automatic cmd(input logic [3:0] c);
    int n;
    av(1'b1, HOST_CMD, {28'h0, c});
    n = 0;
    do
    begin
      av(1'b0, HOST_STATUS, 32'h0);
      n++;
    end
    while (rdq[0] !== 1'b0 && n < 64);
    q = rdq[15:8];
  endtask
  task automatic io(input logic wr, input logic [15:0] a,
                    input logic [7:0] d);
    av(1'b1, HOST_ADDR, {16'h0, a});
    av(1'b1, HOST_WDATA, {24'h0, d});
    cmd({2'b00, wr, 1'b1});
  endtask
  task automatic creg(input logic wr, input logic [7:0] i,
                      input logic [7:0] d);
    io(1'b1, INDEX_PORT, i);
    io(wr, DATA_PORT, d);
  endtask
  // Expected action per route code as {reset, smi, irq}.
  function automatic logic [2:0] act(input int c);
    if (c == 0)
      return 3'b100;
    if (c == 2)
      return 3'b010;
    if (c == 8 || c > 12)
      return 3'b000;
    return 3'b001;
  endfunction
  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Clock, hang guard and the main sequence.
  initial
  begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  // Guard sits far above the roughly six thousand cycles expected.
  initial
  begin
    #1_000_000;
    err_total++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge REF_CLK);
    RST <= 1'b0;
    io(1'b0, DATA_PORT, 8'h00);
    chk(q, 8'hff);
    io(1'b1, INDEX_PORT, KEY_A);
    io(1'b1, INDEX_PORT, 8'h00);
    io(1'b1, INDEX_PORT, KEY_B);
    io(1'b0, DATA_PORT, 8'h00);
    chk(q, 8'hff);
    cmd(4'h4);
    for (int i = 0; i < 13; i++)
    begin
      creg(1'b0, ri[i], 8'h00);
      chk(q, rv[i]);
    end
    io(1'b0, INDEX_PORT, 8'h00);
    chk(q, 8'h3a);
    // Another device selected: the watchdog must ignore and not answer.
    creg(1'b1, IDX_LDS, 8'h02);
    creg(1'b1, IDX_RELOAD1, 8'h77);
    creg(1'b0, IDX_RELOAD1, 8'h00);
    chk(q, 8'hff);
    creg(1'b1, IDX_LDS, WATCHDOG_DEVICE);
    creg(1'b0, IDX_RELOAD1, 8'h00);
    chk(q, 8'h40);
    n_ld = 40 + int'(rnd() & 32'hf);
    creg(1'b1, IDX_RELOAD0, n_ld[7:0]);
    creg(1'b1, IDX_RELOAD1, 8'h00);
    // Every route code: quiet before the count runs out, its action after (none for codes 8 and 13 to 15).
    for (int c = 0; c < 16; c++)
    begin
      creg(1'b1, IDX_ROUTE, 8'(c));
      creg(1'b1, IDX_COUNT0, 8'(rnd()));
      chk({WD_RESET, WD_SMI, WD_IRQ}, 3'b000);
      repeat ((n_ld - 8) * TK) @(posedge REF_CLK);
      chk({WD_RESET, WD_SMI, WD_IRQ}, 3'b000);
      repeat (10 * TK) @(posedge REF_CLK);
      chk({WD_RESET, WD_SMI, WD_IRQ}, act(c));
      if (act(c) == 3'b001)
        chk(WD_IRQ_LINE, c[3:0]);
    end
    creg(1'b0, IDX_COUNT0, 8'h00);
    chk(q, 8'h00);
    creg(1'b1, IDX_ROUTE, 8'h00);
    creg(1'b1, IDX_BASE_HI, 8'h05);
    creg(1'b1, IDX_BASE_LO, 8'h00);
    creg(1'b1, IDX_W1_HI, 8'h02);
    creg(1'b1, IDX_W2_HI, 8'h04);
    creg(1'b1, IDX_MASKS, 8'h3f);
    // Strobes four times at half the timeout; only enabled ones and the count write in the I/O range keep it up.
    for (int k = 0; k < 8; k++)
    begin
      creg(1'b1, IDX_STROBE, sm[k]);
      creg(1'b1, IDX_COUNT0, 8'(rnd()));
      repeat (4)
      begin
        repeat ((n_ld / 2) * TK) @(posedge REF_CLK);
        io(sw[k], sa[k], n_ld[7:0]);
      end
      chk(WD_RESET, !sk[k]);
    end
    // A disabled device stops counting, so no action may appear.
    creg(1'b1, IDX_COUNT0, 8'h00);
    creg(1'b1, IDX_ACTIVATE, 8'h00);
    repeat (2 * n_ld * TK) @(posedge REF_CLK);
    chk(WD_RESET, 1'b0);
    cmd(4'h8);
    io(1'b0, DATA_PORT, 8'h00);
    chk(q, 8'hff);
    print_verdict();
  end
endmodule // lpc_watchdog_timer_tb_top
